//--- core/inertial_output_register_bank.v
// Purpose: read-only rate and acceleration output registers, serial access
// Assumes: sample inputs are on clock; serial pins are asynchronous
// Notes: a read answer is shifted out during the following frame
`timescale 1ns/10ps
`include "inertial_defines.vh"

// Summary of operation
// - each rate axis is one 32-bit twos complement value over two words
// - high rate word: twos complement, 0.02 deg/s per count, zero is 0
// - low rate word holds bits 15:0 of the 32-bit rate value
// - z low rate word only extends z high word resolution
// - each accel axis is one 32-bit twos complement value over two words
// - high accel word: twos complement, 0.8 mg per count, zero is 0
// - low accel word holds bits 15:0 of the 32-bit accel value
// - y accel high word encoded exactly like the x axis
module inertial_output_register_bank
(
  // clock and reset
  input wire clock,
  input wire rst_n,
  // sample results from the signal chain
  input wire sample_valid,
  input wire [31:0] rate_x,
  input wire [31:0] rate_y,
  input wire [31:0] rate_z,
  input wire [31:0] accel_x,
  input wire [31:0] accel_y,
  // serial register interface pins
  input wire sclk,
  input wire cs_n,
  input wire mosi,
  output wire miso,
  output wire miso_oe_n,
  // status
  output reg data_ready_ff,
  output reg comm_error_ff
);

reg [31:0] axis_ff [0:`SLOT_COUNT-1];
reg [7:0] page_ff;
reg [`FRAME_BITS-1:0] tx_word_ff;
reg [`FRAME_BITS-1:0] nxt_tx_word;
reg [2:0] slot;
reg slot_hit;
reg word_high;
wire [`FRAME_BITS-1:0] rx_word;
wire rx_valid;
wire frame_error;
wire [6:0] rx_addr;
wire rx_write;
integer i;

assign rx_addr = rx_word[`FRAME_ADDR_HI:`FRAME_ADDR_LO];
assign rx_write = rx_word[`FRAME_WRITE_BIT];

////////////////////////////////////////////////////////////////////////////
// serial port
spi_word_port #(.WORD_BITS(`FRAME_BITS)) u_port
(
  .clock(clock),
  .rst_n(rst_n),
  .sclk(sclk),
  .cs_n(cs_n),
  .mosi(mosi),
  .miso(miso),
  .miso_oe_n_ff(miso_oe_n),
  .tx_word(tx_word_ff),
  .rx_word_ff(rx_word),
  .rx_valid_ff(rx_valid),
  .frame_error_ff(frame_error)
);

////////////////////////////////////////////////////////////////////////////
// snapshot store: every word of every axis loads on the same sample edge
always @(posedge clock)
begin
  if (!rst_n)
  begin
    for (i = 0; i < `SLOT_COUNT; i = i + 1)
      axis_ff[i] <= `DATA_RESET;
    data_ready_ff <= 1'b0;
  end
  else
  begin
    data_ready_ff <= sample_valid;
    if (sample_valid)
    begin
      axis_ff[`SLOT_RATE_X] <= rate_x;
      axis_ff[`SLOT_RATE_Y] <= rate_y;
      axis_ff[`SLOT_RATE_Z] <= rate_z;
      axis_ff[`SLOT_ACCEL_X] <= accel_x;
      axis_ff[`SLOT_ACCEL_Y] <= accel_y;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// address decode: even byte address, odd byte reads the same word
always @*
begin
  slot = `SLOT_RATE_X;
  slot_hit = 1'b1;
  word_high = 1'b0;
  if ({rx_addr[6:1], 1'b0} == `ADDR_RATE_X_LOW)
    slot = `SLOT_RATE_X;
  else if ({rx_addr[6:1], 1'b0} == `ADDR_RATE_X_HIGH)
  begin
    slot = `SLOT_RATE_X;
    word_high = 1'b1;
  end
  else if ({rx_addr[6:1], 1'b0} == `ADDR_RATE_Y_LOW)
    slot = `SLOT_RATE_Y;
  else if ({rx_addr[6:1], 1'b0} == `ADDR_RATE_Y_HIGH)
  begin
    slot = `SLOT_RATE_Y;
    word_high = 1'b1;
  end
  else if ({rx_addr[6:1], 1'b0} == `ADDR_RATE_Z_LOW)
    slot = `SLOT_RATE_Z;
  else if ({rx_addr[6:1], 1'b0} == `ADDR_RATE_Z_HIGH)
  begin
    slot = `SLOT_RATE_Z;
    word_high = 1'b1;
  end
  else if ({rx_addr[6:1], 1'b0} == `ADDR_ACCEL_X_LOW)
    slot = `SLOT_ACCEL_X;
  else if ({rx_addr[6:1], 1'b0} == `ADDR_ACCEL_X_HIGH)
  begin
    slot = `SLOT_ACCEL_X;
    word_high = 1'b1;
  end
  else if ({rx_addr[6:1], 1'b0} == `ADDR_ACCEL_Y_LOW)
    slot = `SLOT_ACCEL_Y;
  else if ({rx_addr[6:1], 1'b0} == `ADDR_ACCEL_Y_HIGH)
  begin
    slot = `SLOT_ACCEL_Y;
    word_high = 1'b1;
  end
  else
    slot_hit = 1'b0;
end

////////////////////////////////////////////////////////////////////////////
// answer word for the next frame
always @*
begin
  nxt_tx_word = tx_word_ff;
  if (rx_valid && !rx_write)
  begin
    if ({rx_addr[6:1], 1'b0} == `ADDR_PAGE_SEL)
      nxt_tx_word = {8'h00, page_ff};
    else if (page_ff != `DATA_PAGE || !slot_hit)
      nxt_tx_word = `READ_NONE;
    else if (word_high)
      nxt_tx_word = axis_ff[slot][31:16];
    else
      nxt_tx_word = axis_ff[slot][15:0];
  end
  else if (rx_valid)
    nxt_tx_word = `READ_NONE;
end

////////////////////////////////////////////////////////////////////////////
// page select, answer register, frame error status
always @(posedge clock)
begin
  if (!rst_n)
  begin
    page_ff <= `PAGE_RESET;
    tx_word_ff <= `READ_NONE;
    comm_error_ff <= 1'b0;
  end
  else
  begin
    tx_word_ff <= nxt_tx_word;
    if (rx_valid && rx_write && rx_addr == `ADDR_PAGE_SEL)
      page_ff <= rx_word[`FRAME_DATA_HI:`FRAME_DATA_LO];
    if (frame_error)
      comm_error_ff <= 1'b1;
    else if (rx_valid)
      comm_error_ff <= 1'b0;
  end
end

endmodule

//--- include/inertial_defines.vh
// Purpose: shared constants of the inertial output register bank
// Assumes: byte addresses on register page 0x00, 16-bit registers
// Notes: definitions only
`ifndef INERTIAL_DEFINES_VH
`define INERTIAL_DEFINES_VH

// serial frame layout
`define FRAME_BITS 16
`define FRAME_WRITE_BIT 15
`define FRAME_ADDR_HI 14
`define FRAME_ADDR_LO 8
`define FRAME_DATA_HI 7
`define FRAME_DATA_LO 0

// page select and the page that holds the output data
`define ADDR_PAGE_SEL 7'h00
`define DATA_PAGE 8'h00
`define PAGE_RESET 8'h00

// output data register byte addresses
`define ADDR_RATE_X_LOW 7'h10
`define ADDR_RATE_X_HIGH 7'h12
`define ADDR_RATE_Y_LOW 7'h14
`define ADDR_RATE_Y_HIGH 7'h16
`define ADDR_RATE_Z_LOW 7'h18
`define ADDR_RATE_Z_HIGH 7'h1a
`define ADDR_ACCEL_X_LOW 7'h1c
`define ADDR_ACCEL_X_HIGH 7'h1e
`define ADDR_ACCEL_Y_LOW 7'h20
`define ADDR_ACCEL_Y_HIGH 7'h22

// axis slots in the snapshot store
`define SLOT_RATE_X 3'h0
`define SLOT_RATE_Y 3'h1
`define SLOT_RATE_Z 3'h2
`define SLOT_ACCEL_X 3'h3
`define SLOT_ACCEL_Y 3'h4
`define SLOT_COUNT 5

// value of data words before the first sample, and of unmapped reads
`define DATA_RESET 32'h0000_0000
`define READ_NONE 16'h0000

`endif

//--- core/spi_word_port.v
// Purpose: serial word port, one 16-bit word per chip-select frame
// Assumes: mode 3 (idle clock high, sample on rising, shift on falling)
// Notes: pins are synchronised to clock; serial clock well below clock/8
`timescale 1ns/10ps
module spi_word_port
#(
  parameter WORD_BITS = 16
)
(
  // clock and reset
  input wire clock,
  input wire rst_n,
  // serial pins
  input wire sclk,
  input wire cs_n,
  input wire mosi,
  output wire miso,
  output reg miso_oe_n_ff,
  // word side
  input wire [WORD_BITS-1:0] tx_word,
  output reg [WORD_BITS-1:0] rx_word_ff,
  output reg rx_valid_ff,
  output reg frame_error_ff
);

reg sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
reg cs_s1_ff, cs_s2_ff, cs_s3_ff;
reg mosi_s1_ff, mosi_s2_ff;
reg [WORD_BITS-1:0] rx_shift_ff;
reg [WORD_BITS-1:0] tx_shift_ff;
reg [5:0] count_ff;
wire sclk_rise;
wire sclk_fall;
wire cs_start;
wire cs_end;

assign sclk_rise = sclk_s2_ff & ~sclk_s3_ff;
assign sclk_fall = ~sclk_s2_ff & sclk_s3_ff;
assign cs_start = ~cs_s2_ff & cs_s3_ff;
assign cs_end = cs_s2_ff & ~cs_s3_ff;
assign miso = tx_shift_ff[WORD_BITS-1];

////////////////////////////////////////////////////////////////////////////
// pin synchronisers
always @(posedge clock)
begin
  if (!rst_n)
  begin
    sclk_s1_ff <= 1'b1;
    sclk_s2_ff <= 1'b1;
    sclk_s3_ff <= 1'b1;
    cs_s1_ff <= 1'b1;
    cs_s2_ff <= 1'b1;
    cs_s3_ff <= 1'b1;
    mosi_s1_ff <= 1'b0;
    mosi_s2_ff <= 1'b0;
  end
  else
  begin
    sclk_s1_ff <= sclk;
    sclk_s2_ff <= sclk_s1_ff;
    sclk_s3_ff <= sclk_s2_ff;
    cs_s1_ff <= cs_n;
    cs_s2_ff <= cs_s1_ff;
    cs_s3_ff <= cs_s2_ff;
    mosi_s1_ff <= mosi;
    mosi_s2_ff <= mosi_s1_ff;
  end
end

////////////////////////////////////////////////////////////////////////////
// shifters and frame check
always @(posedge clock)
begin
  if (!rst_n)
  begin
    rx_shift_ff <= {WORD_BITS{1'b0}};
    tx_shift_ff <= {WORD_BITS{1'b0}};
    count_ff <= 6'h00;
    rx_word_ff <= {WORD_BITS{1'b0}};
    rx_valid_ff <= 1'b0;
    frame_error_ff <= 1'b0;
    miso_oe_n_ff <= 1'b1;
  end
  else
  begin
    rx_valid_ff <= 1'b0;
    frame_error_ff <= 1'b0;
    if (cs_start)
    begin
      tx_shift_ff <= tx_word;
      count_ff <= 6'h00;
      miso_oe_n_ff <= 1'b0;
    end
    else if (cs_end)
    begin
      miso_oe_n_ff <= 1'b1;
      // a frame counts only with exactly one word of clocks
      if (count_ff == WORD_BITS[5:0])
      begin
        rx_word_ff <= rx_shift_ff;
        rx_valid_ff <= 1'b1;
      end
      else
        frame_error_ff <= 1'b1;
    end
    else if (!cs_s2_ff)
    begin
      if (sclk_rise)
      begin
        rx_shift_ff <= {rx_shift_ff[WORD_BITS-2:0], mosi_s2_ff};
        if (count_ff != 6'h3f)
          count_ff <= count_ff + 6'h01;
      end
      else if (sclk_fall && count_ff != 6'h00)
        tx_shift_ff <= {tx_shift_ff[WORD_BITS-2:0], 1'b0};
    end
  end
end

endmodule

//--- test/bank_asserts.sv
// Purpose: port checks of the output bank
// Assumes: one clock domain
// Notes: bind follows the module
`timescale 1ns/10ps
module bank_asserts
(
  // clock and reset
  input wire clock,
  input wire rst_n,
  // sample side
  input wire sample_valid,
  input wire data_ready_ff,
  // serial side
  input wire sclk,
  input wire cs_n,
  input wire miso,
  input wire miso_oe_n,
  input wire comm_error_ff
);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  a_rdy_follow: assert property (sample_valid |=> data_ready_ff)
    else $error("ready late");
  a_rdy_cause: assert property (data_ready_ff |-> $past(sample_valid))
    else $error("ready unasked");
  a_rdy_once: assert property (data_ready_ff && !sample_valid |=>
    !data_ready_ff) else $error("ready long");
  a_rst_quiet: assert property ($rose(rst_n) |-> miso_oe_n)
    else $error("driving after reset");
  a_oe_idle: assert property (cs_n [*6] |-> miso_oe_n)
    else $error("driving when idle");
  a_oe_frame: assert property (!cs_n [*6] |-> !miso_oe_n)
    else $error("silent in frame");
  a_miso_hold: assert property (($stable(sclk) && !cs_n) [*8] |->
    $stable(miso)) else $error("miso moved");
  a_err_frame: assert property ($changed(comm_error_ff) |->
    $past(cs_n, 2)) else $error("error flag moved in frame");
  cover property (data_ready_ff);
  cover property ($rose(comm_error_ff));
  cover property ($fell(miso_oe_n));
endmodule
bind inertial_output_register_bank bank_asserts chk (.clock(clock),
  .rst_n(rst_n), .sample_valid(sample_valid), .data_ready_ff(data_ready_ff),
  .sclk(sclk), .cs_n(cs_n), .miso(miso), .miso_oe_n(miso_oe_n),
  .comm_error_ff(comm_error_ff));

//--- test/host_model.sv
// Purpose: host side of the serial word port, mode 3
// Assumes: ten clocks per sclk half period
// Notes: flags an answer only for whole 16-bit frames
`timescale 1ns/10ps
module host_model
(
  // clock
  input wire clock,
  // serial pins
  output reg sclk,
  output reg cs_n,
  output reg mosi,
  input wire miso,
  input wire miso_oe_n,
  // answer
  output reg [15:0] rx_word,
  output reg rx_done
);
  // released line reads as pulled high
  wire sdo = miso_oe_n ? 1'h1 : miso;
  // serial clock idles high between frames, as mode 3 wants
  initial {sclk, cs_n, mosi, rx_done} = 4'he;
  task xfer(input [15:0] tx, input integer n);
    integer i;
    reg [15:0] rx;
    begin
      cs_n <= 1'h0;
      repeat (10) @(posedge clock);
      for (i = 15; i > 15 - n; i = i - 1)
      begin
        {sclk, mosi} <= {1'h0, tx[i]};
        repeat (10) @(posedge clock);
        rx = {rx[14:0], sdo};
        sclk <= 1'h1;
        repeat (10) @(posedge clock);
      end
      // deselected data line shows the inverse of its last value
      {cs_n, mosi, rx_word, rx_done} <= {1'h1, ~mosi, rx, n == 16};
      @(posedge clock);
      rx_done <= 1'h0;
      repeat (12) @(posedge clock);
    end
  endtask
endmodule

//--- test/testbench.sv
// Purpose: self-checking bench of the output bank
// Assumes: host model drives the serial pins
// Notes: each answer is checked against the oldest queued note
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done = checks_done + 1; \
  if ((g) !== (e)) begin err_count = err_count + 1; \
  $display("FAIL %0t got %h exp %h", $time, g, e); end end
module testbench;
  // full-scale and edge values of the first pass, one per axis
  function [31:0] fx(input integer k);
    case (k)
      0: fx = 32'h57E4_0000;
      1: fx = 32'hA81C_0000;
      2: fx = 32'hFFFF_FFFF;
      3: fx = 32'h4E20_0000;
      default: fx = 32'hB1E0_0001;
    endcase
  endfunction
  reg clock, rst_n, sample_valid;
  reg [31:0] v [0:4];
  reg [15:0] seed, e;
  reg [15:0] q [$];
  integer err_count, checks_done, r, p;
  wire sclk, cs_n, mosi, miso, miso_oe_n, data_ready_ff, comm_error_ff;
  wire rx_done;
  wire [15:0] rx_word;
  inertial_output_register_bank DUT (.clock(clock), .rst_n(rst_n),
    .sample_valid(sample_valid), .rate_x(v[0]), .rate_y(v[1]),
    .rate_z(v[2]), .accel_x(v[3]), .accel_y(v[4]), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n),
    .data_ready_ff(data_ready_ff), .comm_error_ff(comm_error_ff));
  host_model host (.clock(clock), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe_n(miso_oe_n), .rx_word(rx_word),
    .rx_done(rx_done));
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task rd(input [15:0] cmd, input [15:0] x);
    begin
      q.push_back(x);
      host.xfer(cmd, 16);
    end
  endtask
  task tally_and_finish;
    begin
      // a note never answered is a lost frame
      if (q.size() != 0)
        err_count = err_count + 1;
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial
  begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end
  initial
  begin
    repeat (40000) @(posedge clock);
    err_count = err_count + 1;
    tally_and_finish;
  end
  always @(posedge clock)
    if (rx_done === 1'h1)
    begin
      e = q.pop_front();
      `CHK(rx_word, e)
    end
  initial
  begin
    err_count = 0;
    checks_done = 0;
    seed = 16'h445E;
    {rst_n, sample_valid} = 2'h0;
    for (r = 0; r < 5; r = r + 1)
      v[r] = 32'h0000_0000;
    repeat (3) @(posedge clock);
    rst_n <= 1'h1;
    repeat (4) @(posedge clock);
    rd(16'h1200, 16'h0000);
    rd(16'h0000, 16'h0000);
    // first pass full-scale values, second pass random
    for (p = 0; p < 2; p = p + 1)
    begin
      @(posedge clock);
      for (r = 0; r < 5; r = r + 1)
      begin
        seed = lfsr(lfsr(seed));
        v[r] <= p ? {seed, lfsr(seed)} : fx(r);
      end
      sample_valid <= 1'h1;
      @(posedge clock);
      sample_valid <= 1'h0;
      @(posedge clock);
      `CHK(data_ready_ff, 1'h1)
      rd(16'h1000, 16'h0000);
      for (r = 1; r < 11; r = r + 1)
        rd(16'h1000 + 16'(r) * 16'h0200,
          r[0] ? v[(r - 1) / 2][15:0] : v[(r - 1) / 2][31:16]);
    end
    // data write ignored, off-page read, page select, odd byte address
    rd(16'h92AB, 16'h0000);
    rd(16'h8003, 16'h0000);
    rd(16'h1200, 16'h0000);
    rd(16'h0000, 16'h0000);
    rd(16'h8000, 16'h0003);
    rd(16'h1300, 16'h0000);
    // short frame leaves the pending answer in place
    host.xfer(16'h0000, 9);
    `CHK(comm_error_ff, 1'h1)
    rd(16'h7E00, v[0][31:16]);
    rd(16'h0000, 16'h0000);
    rd(16'h0000, 16'h0000);
    `CHK(comm_error_ff, 1'h0)
    tally_and_finish;
  end
endmodule
